/* File: verilog/ajb_pkg.sv */
// package: opcodes, lengths, cycle counts and carriers for the jump/and decoder
package ajb_pkg;
  localparam logic [4:0] JMP_LOW_PATTERN = 5'h01;
  localparam logic [7:0] OP_AND_DIR_A = 8'h52;
  localparam logic [7:0] OP_AND_DIR_IMM = 8'h53;
  localparam logic [7:0] OP_AND_A_IMM = 8'h54;
  localparam logic [7:0] OP_AND_A_DIR = 8'h55;
  localparam logic [6:0] OP_AND_A_IND_HI = 7'h2b;
  localparam logic [4:0] OP_AND_A_REG_HI = 5'h0b;
  localparam logic [15:0] PC_STEP_JMP = 16'h0002;
  localparam logic [15:0] PC_STEP_ONE = 16'h0001;
  localparam logic [15:0] PC_STEP_TWO = 16'h0002;
  localparam logic [15:0] PC_STEP_THREE = 16'h0003;
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;
  localparam int PC_KEEP_LSB = 11;
  localparam logic [7:0] PORT_ADDR_0 = 8'h80;
  localparam logic [7:0] PORT_ADDR_1 = 8'h90;
  localparam logic [7:0] PORT_ADDR_2 = 8'ha0;
  localparam logic [7:0] PORT_ADDR_3 = 8'hb0;

  typedef enum logic [2:0] {
    AJB_NONE, AJB_JMP, AJB_A_REG, AJB_A_IND, AJB_A_DIR, AJB_A_IMM, AJB_D_A, AJB_D_IMM
  } ajb_kind_t;

  typedef struct packed {
    logic [7:0] op;
    logic [7:0] b1;
    logic [7:0] b2;
  } ajb_instr_t;

  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [7:0] data;
  } ajb_write_t;
endpackage

/* File: verilog/ajb_decode.sv */
// opcode decoder: kind, length and cycle count
`timescale 1ns/10ps
`default_nettype none
module ajb_decode
  import ajb_pkg::*;
(
  // opcode in
  input wire logic [7:0] op_i,
  // decode out
  output var ajb_pkg::ajb_kind_t kind_o,
  output logic [15:0] len_o,
  output logic [1:0] cyc_o
);
  always_comb
  begin
    kind_o = AJB_NONE;
    len_o = PC_STEP_ONE;
    cyc_o = CYC_ONE;
    if (op_i[4:0] == JMP_LOW_PATTERN)
    begin
      kind_o = AJB_JMP;
      len_o = PC_STEP_TWO;
      cyc_o = CYC_TWO;
    end
    else if (op_i[7:3] == OP_AND_A_REG_HI)
      kind_o = AJB_A_REG;
    else if (op_i[7:1] == OP_AND_A_IND_HI)
      kind_o = AJB_A_IND;
    else if (op_i == OP_AND_A_DIR)
    begin
      kind_o = AJB_A_DIR;
      len_o = PC_STEP_TWO;
    end
    else if (op_i == OP_AND_A_IMM)
    begin
      kind_o = AJB_A_IMM;
      len_o = PC_STEP_TWO;
    end
    else if (op_i == OP_AND_DIR_A)
    begin
      kind_o = AJB_D_A;
      len_o = PC_STEP_TWO;
    end
    else if (op_i == OP_AND_DIR_IMM)
    begin
      kind_o = AJB_D_IMM;
      len_o = PC_STEP_THREE;
      cyc_o = CYC_TWO;
    end
  end
endmodule
`default_nettype wire

/* File: verilog/ajb_core.sv */
// execute unit for the block jump and the byte and group
// ==========================================
// Overview of operation
// - jump adds two to pc, keeps pc[15:11], loads op[7:5] and byte two.
// - jump is two bytes, two cycles, low opcode bits 00001.
// - and writes bitwise and of operands to destination, flags untouched.
// - accumulator forms: register, indirect one byte; direct, immediate two; one cycle.
// - direct destination accepts accumulator (0x52, two bytes, one cycle) or immediate.
// - port destination reads original value from output latch, not pins.
// - direct destination is any ram byte or register; zero mask bits clear.
`timescale 1ns/10ps
`default_nettype none
module ajb_core
  import ajb_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // instruction stream
  input wire logic instr_valid_i,
  input wire ajb_pkg::ajb_instr_t instr_i,
  input wire logic [15:0] pc_i,
  // operands from core state
  input wire logic [7:0] acc_i,
  input wire logic [63:0] working_register_i,
  input wire logic [7:0] dir_rd_data_i,
  input wire logic [7:0] ind_rd_data_i,
  input wire logic [7:0] port_latch_i,
  // read addresses (combinational)
  output logic [7:0] dir_rd_addr_o,
  output logic [7:0] ind_rd_addr_o,
  output logic port_sel_o,
  // results
  output logic busy_o,
  output logic done_o,
  output logic unknown_o,
  output logic [15:0] pc_o,
  output logic acc_we_o,
  output logic [7:0] acc_o,
  output var ajb_pkg::ajb_write_t dir_wr_o
);
  import ajb_pkg::*;

  ajb_kind_t kind;
  logic [15:0] len;
  logic [1:0] cyc;
  logic [1:0] wait_cnt, next_wait_cnt;
  logic done, next_done, unk, next_unk, acc_we, next_acc_we;
  logic [15:0] pc_r, next_pc;
  logic [7:0] acc_r, next_acc;
  ajb_write_t wr, next_wr;
  logic [7:0] src, orig, wreg, ptr;
  logic is_port;

  function automatic logic [7:0] pick_reg(input logic [63:0] bank, input logic [2:0] idx);
    pick_reg = bank[{idx, 3'h0} +: 8];
  endfunction

  function automatic logic port_addr(input logic [7:0] a);
    port_addr = (a == PORT_ADDR_0) || (a == PORT_ADDR_1) || (a == PORT_ADDR_2)
      || (a == PORT_ADDR_3);
  endfunction

  ajb_decode u_dec (
    .op_i(instr_i.op),
    .kind_o(kind),
    .len_o(len),
    .cyc_o(cyc)
  );

  // ==========================================
  // operand selection
  always_comb
  begin
    wreg = pick_reg(working_register_i, instr_i.op[2:0]);
    ptr = pick_reg(working_register_i, {2'h0, instr_i.op[0]});
    ind_rd_addr_o = ptr;
    dir_rd_addr_o = instr_i.b1;
    // ports read back from the latch so pin loading cannot corrupt bits
    is_port = port_addr(instr_i.b1) && ((kind == AJB_D_A) || (kind == AJB_D_IMM));
    port_sel_o = is_port;
    orig = is_port ? port_latch_i : dir_rd_data_i;
    case (kind)
      AJB_A_REG: src = wreg;
      AJB_A_IND: src = ind_rd_data_i;
      AJB_A_DIR: src = dir_rd_data_i;
      AJB_A_IMM: src = instr_i.b1;
      AJB_D_A: src = acc_i;
      AJB_D_IMM: src = instr_i.b2;
      default: src = 8'hff;
    endcase
  end

  // ==========================================
  // execute
  always_comb
  begin
    next_wait_cnt = wait_cnt;
    next_done = 1'b0;
    next_unk = 1'b0;
    next_acc_we = 1'b0;
    next_pc = pc_r;
    next_acc = acc_r;
    next_wr = '0;
    if (wait_cnt != 2'h0)
    begin
      next_wait_cnt = wait_cnt - 2'h1;
      next_done = (wait_cnt == CYC_ONE);
    end
    else if (instr_valid_i)
    begin
      next_wait_cnt = cyc - CYC_ONE;
      next_done = (cyc == CYC_ONE);
      next_pc = pc_i + len;
      case (kind)
        AJB_JMP:
        begin
          // advance by two then replace low eleven bits
          next_pc = pc_i + PC_STEP_JMP;
          next_pc = {next_pc[15:PC_KEEP_LSB], instr_i.op[7:5], instr_i.b1};
        end
        AJB_A_REG, AJB_A_IND, AJB_A_DIR, AJB_A_IMM:
        begin
          // and into accumulator, no flag outputs exist
          next_acc = acc_i & src;
          next_acc_we = 1'b1;
        end
        AJB_D_A, AJB_D_IMM:
        begin
          // zero mask bits clear destination bits
          next_wr.en = 1'b1;
          next_wr.addr = instr_i.b1;
          next_wr.data = orig & src;
        end
        default:
        begin
          next_unk = 1'b1;
          next_done = 1'b1;
          next_wait_cnt = 2'h0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wait_cnt <= 2'h0;
      done <= 1'b0;
      unk <= 1'b0;
      acc_we <= 1'b0;
      pc_r <= 16'h0000;
      acc_r <= 8'h00;
      wr <= '0;
    end
    else
    begin
      wait_cnt <= next_wait_cnt;
      done <= next_done;
      unk <= next_unk;
      acc_we <= next_acc_we;
      pc_r <= next_pc;
      acc_r <= next_acc;
      wr <= next_wr;
    end
  end

  assign busy_o = (wait_cnt != 2'h0);
  assign done_o = done;
  assign unknown_o = unk;
  assign pc_o = pc_r;
  assign acc_we_o = acc_we;
  assign acc_o = acc_r;
  assign dir_wr_o = wr;

  // ==========================================
  // checks
  AST_JMP_TARGET: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (instr_valid_i && !busy_o && kind == AJB_JMP) |=> (pc_o[10:0] ==
      {$past(instr_i.op[7:5]), $past(instr_i.b1)}))
    else $error("jump target low bits wrong");
  AST_JMP_TWO_CYC: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (instr_valid_i && !busy_o && kind == AJB_JMP) |=> (busy_o && !done_o) ##1 done_o)
    else $error("jump not two cycles");
  AST_ACC_AND: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (instr_valid_i && !busy_o && kind == AJB_A_IMM) |=>
      (acc_we_o && acc_o == ($past(acc_i) & $past(instr_i.b1))))
    else $error("accumulator and result wrong");
  AST_ACC_ONE_CYC: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (instr_valid_i && !busy_o && kind == AJB_A_DIR) |=> (done_o && !busy_o
      && pc_o == $past(pc_i) + PC_STEP_TWO))
    else $error("accumulator direct form timing or length wrong");
  AST_DIR_A: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (instr_valid_i && !busy_o && instr_i.op == OP_AND_DIR_A) |=>
      (dir_wr_o.en && done_o && dir_wr_o.addr == $past(instr_i.b1)))
    else $error("direct accumulator form wrong");
  AST_PORT_LATCH: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (instr_valid_i && !busy_o && kind == AJB_D_A && port_sel_o) |=>
      (dir_wr_o.data == ($past(port_latch_i) & $past(acc_i))))
    else $error("port value not taken from latch");
  AST_MASK_CLEAR: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    dir_wr_o.en |-> ((dir_wr_o.data & ~$past(src)) == 8'h00))
    else $error("masked bit survived");
  AST_REG_SEL: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (instr_valid_i && !busy_o && kind == AJB_A_REG) |=>
      (acc_o == ($past(acc_i) & $past(wreg)) && $past(wreg) ==
        $past(working_register_i[{instr_i.op[2:0], 3'h0} +: 8])))
    else $error("working register selection wrong");
  // judged from the inputs, so a wrong operand mux cannot hide behind src
  AST_MASK_KEEP: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (instr_valid_i && !busy_o && kind == AJB_D_IMM && !port_sel_o) |=>
      (dir_wr_o.data == ($past(dir_rd_data_i) & $past(instr_i.b2))))
    else $error("direct mask result wrong");
  AST_BUSY_HOLD: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    busy_o |=> (!acc_we_o && !dir_wr_o.en && !unknown_o))
    else $error("instruction taken while busy");
  AST_IND_SEL: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (instr_valid_i && !busy_o && kind == AJB_A_IND) |->
      (ind_rd_addr_o == working_register_i[{instr_i.op[0], 3'h0} +: 8]))
    else $error("pointer register selection wrong");
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// testbench: drives the block jump and byte and unit and checks its results
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import ajb_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic instr_valid_i = 1'b0;
  ajb_instr_t instr_i = '0;
  logic [15:0] pc_i = 16'h0000;
  logic [7:0] acc_i = 8'hc3;
  logic [63:0] working_register_i = 64'h77665544332211_55;
  logic [7:0] dir_rd_data_i = 8'h3c;
  logic [7:0] ind_rd_data_i = 8'h96;
  logic [7:0] port_latch_i = 8'hf0;
  logic [7:0] dir_rd_addr_o;
  logic [7:0] ind_rd_addr_o;
  logic port_sel_o;
  logic busy_o;
  logic done_o;
  logic unknown_o;
  logic [15:0] pc_o;
  logic acc_we_o;
  logic [7:0] acc_o;
  ajb_write_t dir_wr_o;
  int failures = 0;
  int num_checks = 0;

  always #2.5 sys_clk_i = ~sys_clk_i;

  ajb_core i_dut (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .instr_valid_i(instr_valid_i),
    .instr_i(instr_i), .pc_i(pc_i), .acc_i(acc_i), .working_register_i(working_register_i),
    .dir_rd_data_i(dir_rd_data_i), .ind_rd_data_i(ind_rd_data_i),
    .port_latch_i(port_latch_i), .dir_rd_addr_o(dir_rd_addr_o),
    .ind_rd_addr_o(ind_rd_addr_o), .port_sel_o(port_sel_o), .busy_o(busy_o),
    .done_o(done_o), .unknown_o(unknown_o), .pc_o(pc_o), .acc_we_o(acc_we_o),
    .acc_o(acc_o), .dir_wr_o(dir_wr_o)
  );

  // ==========================================
  // shared tasks
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask

  // valid stays up so one-cycle ops can run back to back
  task automatic issue(input logic [7:0] op, input logic [7:0] b1, input logic [7:0] b2);
    instr_i = '{op, b1, b2};
    instr_valid_i = 1'b1;
    @(posedge sys_clk_i);
    #1;
  endtask

  task automatic idle();
    instr_valid_i = 1'b0;
    @(posedge sys_clk_i);
    #1;
  endtask

  task automatic and_acc(input logic [7:0] op, input logic [7:0] b1, input logic [7:0] exp,
      input logic [15:0] len);
    issue(op, b1, 8'h00);
    chk("acc_we", 16'h0001, acc_we_o);
    chk("unknown", 16'h0000, unknown_o);
    chk("acc", exp, acc_o);
    chk("done", 16'h0001, done_o);
    chk("pc", pc_i + len, pc_o);
    chk("wr_en", 16'h0000, dir_wr_o.en);
  endtask

  task automatic dir_op(input logic [7:0] op, input logic [7:0] adr, input logic [7:0] b2,
      input logic psel, input logic [7:0] exp, input logic [15:0] len);
    issue(op, adr, b2);
    chk("port_sel", psel, port_sel_o);
    chk("wr_en", 16'h0001, dir_wr_o.en);
    chk("wr_addr", adr, dir_wr_o.addr);
    chk("wr_data", exp, dir_wr_o.data);
    chk("pc", pc_i + len, pc_o);
    chk("acc_we", 16'h0000, acc_we_o);
    chk("done", {15'h0000, len == PC_STEP_TWO}, done_o);
    if (len != PC_STEP_TWO)
    begin
      idle();
      chk("done2", 16'h0001, done_o);
    end
  endtask

  // ==========================================
  // scenarios
  task automatic t_jump();
    logic [15:0] nxt;
    for (int a = 0; a < 8; a++)
    begin
      pc_i = a[0] ? 16'h0345 : 16'hf7fe;
      nxt = pc_i + PC_STEP_JMP;
      issue({a[2:0], JMP_LOW_PATTERN}, 8'h23, 8'h00);
      chk("jmp_pc", {nxt[15:11], a[2:0], 8'h23}, pc_o);
      chk("jmp_busy", 16'h0001, busy_o);
      chk("jmp_done", 16'h0000, done_o);
      // an and offered while busy must be ignored
      instr_i = '{OP_AND_A_IMM, 8'h00, 8'h00};
      @(posedge sys_clk_i);
      #1;
      chk("jmp_done2", 16'h0001, done_o);
      chk("refused", 16'h0000, acc_we_o);
      idle();
      chk("refused2", 16'h0000, acc_we_o);
    end
  endtask

  task automatic t_acc();
    pc_i = 16'hfffe;
    for (int r = 0; r < 8; r++)
      and_acc({OP_AND_A_REG_HI, r[2:0]}, 8'h30, acc_i & working_register_i[8*r +: 8],
          PC_STEP_ONE);
    for (int i = 0; i < 2; i++)
    begin
      and_acc({OP_AND_A_IND_HI, i[0]}, 8'h30, acc_i & ind_rd_data_i, PC_STEP_ONE);
      chk("ind_addr", working_register_i[8*i +: 8], ind_rd_addr_o);
    end
    and_acc(OP_AND_A_DIR, 8'h30, acc_i & dir_rd_data_i, PC_STEP_TWO);
    chk("dir_addr", 16'h0030, dir_rd_addr_o);
    and_acc(OP_AND_A_IMM, 8'h0f, acc_i & 8'h0f, PC_STEP_TWO);
    idle();
  endtask

  task automatic t_dir();
    logic [7:0] pa [4] = '{PORT_ADDR_0, PORT_ADDR_1, PORT_ADDR_2, PORT_ADDR_3};
    pc_i = 16'h0100;
    dir_op(OP_AND_DIR_A, 8'h40, 8'h00, 1'b0, acc_i & dir_rd_data_i, PC_STEP_TWO);
    foreach (pa[k])
      dir_op(OP_AND_DIR_A, pa[k], 8'h00, 1'b1, acc_i & port_latch_i, PC_STEP_TWO);
    dir_op(OP_AND_DIR_IMM, 8'h7f, 8'h73, 1'b0, dir_rd_data_i & 8'h73, PC_STEP_THREE);
    dir_op(OP_AND_DIR_IMM, pa[1], 8'h73, 1'b1, port_latch_i & 8'h73, PC_STEP_THREE);
    idle();
  endtask

  task automatic t_unk();
    logic [7:0] ops [2] = '{8'h50, 8'ha5};
    pc_i = 16'h2000;
    foreach (ops[k])
    begin
      issue(ops[k], 8'h00, 8'h00);
      chk("unknown", 16'h0001, unknown_o);
      chk("unk_pc", pc_i + PC_STEP_ONE, pc_o);
      chk("unk_acc_we", 16'h0000, acc_we_o);
    end
    idle();
  endtask

  // reset lands in the second cycle of a jump
  task automatic t_reset();
    pc_i = 16'h0345;
    issue({3'h1, JMP_LOW_PATTERN}, 8'h23, 8'h00);
    rst_i = 1'b1;
    instr_valid_i = 1'b0;
    #1;
    chk("rst_busy", 16'h0000, busy_o);
    chk("rst_pc", 16'h0000, pc_o);
    chk("rst_acc", 16'h0000, acc_o);
    @(posedge sys_clk_i);
    #1;
    rst_i = 1'b0;
    chk("rst_done", 16'h0000, done_o);
    and_acc(OP_AND_A_IMM, 8'h81, acc_i & 8'h81, PC_STEP_TWO);
    idle();
  endtask

  task automatic report_and_stop();
    if (failures == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ==========================================
  // main sequence and watchdog
  initial
  begin
    repeat (2) @(posedge sys_clk_i);
    #1;
    rst_i = 1'b0;
    t_jump();
    t_acc();
    t_dir();
    t_unk();
    t_reset();
    report_and_stop();
  end

  // the run needs about 60 cycles, so this leaves a wide margin
  initial
  begin
    #5000;
    failures++;
    report_and_stop();
  end
endmodule
`default_nettype wire
